// file: hdl/scsc_control_port.sv
/*
  scsc_control_port: serial strobe port, shift register and shadow
  register holding the synthesizer control word, with field outputs.
  assumes: strobe, request, direction and data pins are asynchronous and
  change slowly against sys_clk_in; the data pin is resolved outside.
*/
// Operation
// - write: request low till last bit, then high loads the shadow
// - pll starts relocking as soon as the shadow is loaded
// - read: direction high; request on first bit refreshes shift reg
// - a read never changes shadow, settings or clocks
// - read bit shown after strobe falls, shifted on strobe rise
// - all multi-bit fields travel least significant bit first
// - bit 1 picks large or small differential swing, power-up small
// - bit 2 picks crystal or external reference, power-up crystal
// - bits 4:3 pick loop filter, external after power-up
// - bit 5 stops load clock and divider; gate pin gates output only
// - bit 6 holds pixel clock low, bit 7 drops differential outputs
// - bit 8 picks charge pump current, low current after power-up
// - bit 9 inverts charge pump polarity, normal after power-up
// - bit 10 floats charge pump, bit 11 disables oscillator
// - bit 12 enables the external oscillator path
// - bit 13 clamps oscillator in reset, set after power-up
// - bits 15:14 select output clock source, crystal half first
// - bits 16-19 hold p modulus minus one, power-up three
// - bits 20-23 hold load modulus minus one, power-up three
// - bits 24-33 hold reference modulus, power-up 20, never zero
// - bits 34-47 hold feedback modulus, power-up 120, never 0 or 1
// - shadow takes every setting from the shift reg in one cycle
// - change of bits 14-19 freezes and restarts the pixel clocks
`timescale 1ns/100ps
module scsc_control_port #(
  parameter int FREEZE_CYCLES = scsc_pkg::DEGLITCH_CYCLES
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       chip_select_strobe_in,
  input  wire logic                       xfer_request_in,
  input  wire logic                       read_not_write_in,
  input  wire logic                       serial_data_in,
  output logic                            serial_data_out,
  output logic                            serial_data_oe_out,
  input  wire logic                       load_clock_gate_pin_in,
  output logic                            differential_out_large_swing_out,
  output logic                            ext_ref_select_out,
  output logic [scsc_pkg::FILTER_W-1:0]   loop_filter_sel_out,
  output logic                            load_clock_stop_out,
  output logic                            load_clock_gate_out,
  output logic                            pixel_clock_hold_out,
  output logic                            differential_out_out_low_out,
  output logic                            cp_high_current_out,
  output logic                            cp_invert_out,
  output logic                            cp_hiz_out,
  output logic                            osc_disable_out,
  output logic                            external_osc_path_on_out,
  output logic                            osc_reset_bit_out,
  output logic [scsc_pkg::MUX_W-1:0]      clock_mux_sel_out,
  output logic [scsc_pkg::P_W-1:0]        p_modulus_m1_out,
  output logic [scsc_pkg::L_W-1:0]        l_modulus_m1_out,
  output logic [scsc_pkg::R_W-1:0]        r_modulus_out,
  output logic [scsc_pkg::N_W-1:0]        n_modulus_out,
  output logic                            pll_relock_out,
  output logic                            pclk_freeze_out
);
  import scsc_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] shadow;
    scsc_phase_t       phase;
    logic              req;
    logic              rd;
    logic              dout;
    logic              relock;
    logic              restart;
  } scsc_state_t;

  scsc_state_t state_reg;
  scsc_state_t state_next;

  logic [4:0]        pins_sync;
  logic              cs_s;
  logic              req_s;
  logic              rd_s;
  logic              din_s;
  logic              gate_s;
  logic [WORD_W-1:0] shift_in_write;
  logic [WORD_W-1:0] shift_rotate;

  // every pin level crosses two flops before use; the strobe goes in
  // inverted so a cleared synchroniser reads its idle high level
  scsc_sync #(
    .W (5)
  ) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({load_clock_gate_pin_in, serial_data_in, read_not_write_in,
                  xfer_request_in, ~chip_select_strobe_in}),
    .sync_out   (pins_sync)
  );

  assign cs_s   = ~pins_sync[0];
  assign req_s  = pins_sync[1];
  assign rd_s   = pins_sync[2];
  assign din_s  = pins_sync[3];
  assign gate_s = pins_sync[4];

  // new bits enter at the top so the first bit ends in serial bit 1
  assign shift_in_write = {din_s, state_reg.shift[WORD_W-1:1]};
  assign shift_rotate   = {state_reg.shift[0], state_reg.shift[WORD_W-1:1]};

  // strobe sequencer: latch controls on fall, act on rise
  always_comb begin
    state_next         = state_reg;
    state_next.relock  = 1'b0;
    state_next.restart = 1'b0;
    case (state_reg.phase)
      SCSC_PH_HIGH: begin
        if (!cs_s) begin
          state_next.phase = SCSC_PH_LOW;
          state_next.req   = req_s;
          state_next.rd    = rd_s;
          if (rd_s && req_s) begin
            state_next.shift = state_reg.shadow;
            state_next.dout  = state_reg.shadow[0];
          end else if (rd_s) begin
            state_next.dout = state_reg.shift[0];
          end
        end
      end
      SCSC_PH_LOW: begin
        if (cs_s) begin
          state_next.phase = SCSC_PH_HIGH;
          if (state_reg.rd) begin
            state_next.shift = shift_rotate;
          end else begin
            state_next.shift = shift_in_write;
            if (state_reg.req) begin
              state_next.shadow  = shift_in_write;
              state_next.relock  = 1'b1;
              state_next.restart =
                shift_in_write[IDX_GLITCH_LO +: GLITCH_W] !=
                state_reg.shadow[IDX_GLITCH_LO +: GLITCH_W];
            end
          end
        end
      end
      default: begin
        state_next.phase = SCSC_PH_HIGH;
      end
    endcase
  end

  // register the state; power-up defaults stand in for a reset pin
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg        <= '0;
      state_reg.shift  <= WORD_RESET;
      state_reg.shadow <= WORD_RESET;
      state_reg.phase  <= SCSC_PH_HIGH;
    end else begin
      state_reg <= state_next;
    end
  end

  // pixel clock freeze after a source or p modulus change
  scsc_deglitch #(
    .CYCLES (FREEZE_CYCLES)
  ) u_deglitch (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .start_in   (state_reg.restart),
    .freeze_out (pclk_freeze_out)
  );

  // data pin driven from a read bit's strobe fall until the next write bit's fall
  assign serial_data_out    = state_reg.dout;
  assign serial_data_oe_out = state_reg.rd;
  assign pll_relock_out     = state_reg.relock;

  // settings taken straight from the shadow register; the load clock gate comes from the synchronised gate pin
  assign differential_out_large_swing_out = state_reg.shadow[IDX_DIFFERENTIAL_OUT_LARGE];
  assign ext_ref_select_out   = state_reg.shadow[IDX_EXT_REF];
  assign loop_filter_sel_out  =
    state_reg.shadow[IDX_FILTER_LO +: FILTER_W];
  assign load_clock_stop_out  = state_reg.shadow[IDX_LOAD_STOP];
  assign load_clock_gate_out  = gate_s;
  assign pixel_clock_hold_out = state_reg.shadow[IDX_PCLK_HOLD];
  assign differential_out_out_low_out     = state_reg.shadow[IDX_DIFFERENTIAL_OUT_LOW];
  assign cp_high_current_out  = state_reg.shadow[IDX_CP_HIGH];
  assign cp_invert_out        = state_reg.shadow[IDX_CP_INVERT];
  assign cp_hiz_out           = state_reg.shadow[IDX_CP_HIZ];
  assign osc_disable_out      = state_reg.shadow[IDX_OSC_OFF];
  assign external_osc_path_on_out =
    state_reg.shadow[IDX_EXT_OSC];
  assign osc_reset_bit_out    = state_reg.shadow[IDX_OSC_RESET];
  assign clock_mux_sel_out    =
    state_reg.shadow[IDX_MUX_LO +: MUX_W];
  assign p_modulus_m1_out     = state_reg.shadow[IDX_P_LO +: P_W];
  assign l_modulus_m1_out     = state_reg.shadow[IDX_L_LO +: L_W];
  assign r_modulus_out        = state_reg.shadow[IDX_R_LO +: R_W];
  assign n_modulus_out        = state_reg.shadow[IDX_N_LO +: N_W];

  // helpers for the checks below
  logic shift_lsb;
  logic rise_seen;
  logic fall_seen;
  assign shift_lsb = state_reg.shift[0];
  assign rise_seen = state_reg.phase == SCSC_PH_LOW && cs_s;
  assign fall_seen = state_reg.phase == SCSC_PH_HIGH && !cs_s;
  logic [GLITCH_W-1:0] glitch_span;
  assign glitch_span = state_reg.shadow[IDX_GLITCH_LO +: GLITCH_W];

  default clocking cp_cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // write path: load, relock and bit order
  load_on_last_a: assert property (
    rise_seen && !state_reg.rd && state_reg.req
      |=> state_reg.shadow == state_reg.shift && pll_relock_out)
    else $error("final write bit did not load the shadow");

  relock_on_load_a: assert property (
    $changed(state_reg.shadow) |-> pll_relock_out)
    else $error("shadow changed without a relock pulse");

  // read path: shadow untouched, refresh and bit shown
  read_keeps_shadow_a: assert property (
    state_reg.rd |=> $stable(state_reg.shadow))
    else $error("read disturbed the shadow register");

  read_refresh_a: assert property (
    fall_seen && rd_s && req_s
      |=> state_reg.shift == $past(state_reg.shadow))
    else $error("read request did not refresh the shift register");

  read_bit_shown_a: assert property (
    fall_seen && rd_s && !req_s |=> serial_data_out == $past(shift_lsb)
      && serial_data_oe_out)
    else $error("read bit not presented after strobe fall");

  write_lsb_first_a: assert property (
    rise_seen && !state_reg.rd
      |=> state_reg.shift[WORD_W-1] == $past(din_s))
    else $error("write bit entered at the wrong end");

  no_final_request_a: assert property (
    rise_seen && !state_reg.req |=> $stable(state_reg.shadow))
    else $error("shadow loaded without final request");

  // power-up word and the freeze window
  reset_defaults_a: assert property (
    $past(rst_in) |-> osc_reset_bit_out && n_modulus_out == N_RESET
      && r_modulus_out == R_RESET && clock_mux_sel_out == MUX_RESET)
    else $error("power-up defaults wrong");

  change_freezes_a: assert property (
    state_reg.restart |=> pclk_freeze_out [*4])
    else $error("source change did not freeze the pixel clocks");

  // the shadow moves only at a strobe rise
  shadow_hold_a: assert property (
    !rise_seen |=> $stable(state_reg.shadow))
    else $error("shadow changed away from a strobe rise");

  // a load needs a strobe fall before each rise, so loads never abut
  relock_pulse_a: assert property (
    pll_relock_out |=> !pll_relock_out)
    else $error("relock pulse longer than one cycle");

  // a read rise rotates bit 0 back in at the top
  read_rotate_a: assert property (
    rise_seen && state_reg.rd
      |=> state_reg.shift[WORD_W-1] == $past(shift_lsb)
      && state_reg.shift[WORD_W-2:0] == $past(state_reg.shift[WORD_W-1:1]))
    else $error("read rise did not advance the shift register");

  // pin drive follows the direction latched at each fall
  read_drive_a: assert property (
    fall_seen |=> serial_data_oe_out == $past(rd_s))
    else $error("data pin drive does not follow the direction");

  // the pin stays released and the port idle after reset
  idle_after_reset_a: assert property (
    $past(rst_in) |-> state_reg.phase == SCSC_PH_HIGH
      && !serial_data_oe_out)
    else $error("port not idle after reset");

  // a load that moves mux select or p modulus freezes the outputs
  span_freeze_a: assert property (
    pll_relock_out && glitch_span != $past(glitch_span)
      |=> pclk_freeze_out)
    else $error("clock source change without freeze");

  // a load that keeps both leaves the outputs running
  span_quiet_a: assert property (
    pll_relock_out && glitch_span == $past(glitch_span)
      |-> !state_reg.restart)
    else $error("freeze started without a clock source change");

  // main scenarios
  write_load_c: cover property (rise_seen && !state_reg.rd
    && state_reg.req);
  read_refresh_c: cover property (fall_seen && rd_s && req_s);
  read_plain_c: cover property (fall_seen && rd_s && !req_s);
  deglitch_c: cover property (state_reg.restart);

endmodule : scsc_control_port

// file: pkg/scsc_pkg.sv
/*
  scsc_pkg: constants and types for the serial clock synth control port.
  assumes: shared by the control port top and its deglitch helper.
*/
package scsc_pkg;

  // control word geometry; index 0 holds serial bit 1
  localparam int WORD_W = 47;

  // single-bit field positions
  localparam int IDX_DIFFERENTIAL_OUT_LARGE = 0;
  localparam int IDX_EXT_REF    = 1;
  localparam int IDX_LOAD_STOP  = 4;
  localparam int IDX_PCLK_HOLD  = 5;
  localparam int IDX_DIFFERENTIAL_OUT_LOW   = 6;
  localparam int IDX_CP_HIGH    = 7;
  localparam int IDX_CP_INVERT  = 8;
  localparam int IDX_CP_HIZ     = 9;
  localparam int IDX_OSC_OFF    = 10;
  localparam int IDX_EXT_OSC    = 11;
  localparam int IDX_OSC_RESET  = 12;

  // multi-bit fields, low index and width
  localparam int IDX_FILTER_LO = 2;
  localparam int FILTER_W      = 2;
  localparam int IDX_MUX_LO    = 13;
  localparam int MUX_W         = 2;
  localparam int IDX_P_LO      = 15;
  localparam int P_W           = 4;
  localparam int IDX_L_LO      = 19;
  localparam int L_W           = 4;
  localparam int IDX_R_LO      = 23;
  localparam int R_W           = 10;
  localparam int IDX_N_LO      = 33;
  localparam int N_W           = 14;

  // span watched by the deglitcher: mux select and p modulus
  localparam int IDX_GLITCH_LO = 13;
  localparam int GLITCH_W      = 6;

  // power-up field values
  localparam logic [N_W-1:0] N_RESET   = 14'h0078;
  localparam logic [R_W-1:0] R_RESET   = 10'h014;
  localparam logic [L_W-1:0] L_RESET   = 4'h3;
  localparam logic [P_W-1:0] P_RESET   = 4'h3;
  localparam logic [MUX_W-1:0] MUX_RESET = 2'h0;
  localparam logic OSC_RESET_RESET       = 1'b1;
  localparam logic [11:0] LOW_BITS_RESET = 12'h000;

  localparam logic [WORD_W-1:0] WORD_RESET = {N_RESET, R_RESET, L_RESET,
    P_RESET, MUX_RESET, OSC_RESET_RESET, LOW_BITS_RESET};

  // cycles the pixel clock outputs stay frozen after a source change
  localparam int DEGLITCH_CYCLES = 64;
  localparam int DEGLITCH_CNT_W  = 8;

  // serial strobe phase
  typedef enum logic [1:0] {
    SCSC_PH_HIGH = 2'b01,
    SCSC_PH_LOW  = 2'b10
  } scsc_phase_t;

endpackage : scsc_pkg

// file: hdl/scsc_sync.sv
/*
  scsc_sync: two-flop synchroniser for a bundle of pin levels.
  assumes: inputs are asynchronous levels; clock is sys_clk_in.
*/
`timescale 1ns/100ps
module scsc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import scsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } scsc_sync_state_t;

  scsc_sync_state_t state_reg;
  scsc_sync_state_t state_next;

  // first stage feeds only the second
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = async_in;
    state_next.stable = state_reg.meta;
  end

  // register the state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

endmodule : scsc_sync

// file: hdl/scsc_deglitch.sv
/*
  scsc_deglitch: holds a freeze level for a fixed count after a start pulse.
  assumes: start_in is a one-cycle pulse on sys_clk_in.
*/
`timescale 1ns/100ps
module scsc_deglitch #(
  parameter int CYCLES = scsc_pkg::DEGLITCH_CYCLES
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  output logic      freeze_out
);
  import scsc_pkg::*;

  typedef struct packed {
    logic [DEGLITCH_CNT_W-1:0] count;
    logic                      freeze;
  } scsc_dg_state_t;

  localparam logic [DEGLITCH_CNT_W-1:0] CNT_LOAD =
    DEGLITCH_CNT_W'(CYCLES - 1);

  scsc_dg_state_t state_reg;
  scsc_dg_state_t state_next;

  // a new start restarts the freeze window
  always_comb begin
    state_next = state_reg;
    if (start_in) begin
      state_next.count  = CNT_LOAD;
      state_next.freeze = 1'b1;
    end else if (state_reg.count != '0) begin
      state_next.count = state_reg.count - 1'b1;
    end else begin
      state_next.freeze = 1'b0;
    end
  end

  // register the state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign freeze_out = state_reg.freeze;

  default clocking dg_cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // freeze lasts at least eight cycles after a start
  freeze_hold_a: assert property (
    start_in |=> freeze_out [*8])
    else $error("freeze released too early");

  // freeze ends once the count runs out
  freeze_end_a: assert property (
    freeze_out && state_reg.count == '0 && !start_in |=> !freeze_out)
    else $error("freeze outlived its count");

  freeze_seen_c: cover property (start_in ##1 freeze_out ##[1:300]
    !freeze_out);

endmodule : scsc_deglitch

// file: verif/scsc_host_model.sv
/*
  scsc_host_model: host cpu driving the serial strobe port bit by bit.
  assumes: driven from the bench clock; data line resolved by the bench.
*/
`timescale 1ns/100ps
module scsc_host_model (
  input  wire logic sys_clk_in,
  input  wire logic data_line_in,
  output logic      strobe_out,
  output logic      xfer_req_out,
  output logic      rnw_out,
  output logic      data_drive_out
);
  import scsc_pkg::*;

  // idle levels: strobe high, request low, data line driven
  initial begin
    strobe_out     = 1'b1;
    xfer_req_out   = 1'b0;
    rnw_out        = 1'b1;
    data_drive_out = 1'b0;
  end

  // one strobe cycle; levels settle four clocks before the fall
  task automatic do_bit(input logic req, input logic dir, input logic d,
                        output logic q);
    @(negedge sys_clk_in);
    xfer_req_out   = req;
    rnw_out        = dir;
    data_drive_out = dir ? ~data_drive_out : d; // released: toggles
    repeat (4) @(negedge sys_clk_in);
    strobe_out = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    q          = data_line_in;
    strobe_out = 1'b1;
    repeat (5) @(negedge sys_clk_in);
  endtask : do_bit

  // lsb of the word first; request only on the last bit if fin set
  task automatic write_word(input logic [WORD_W-1:0] w, input logic fin);
    logic q;
    for (int i = 0; i < WORD_W; i++) begin
      do_bit(i == WORD_W - 1 && fin, 1'b0, w[i], q);
    end
  endtask : write_word

  // request on the first bit refreshes the shift register if first set
  task automatic read_word(input logic first, output logic [WORD_W-1:0] w);
    for (int i = 0; i < WORD_W; i++) begin
      do_bit((i == 0) ? first : 1'b0, 1'b1, 1'b0, w[i]);
    end
  endtask : read_word
endmodule : scsc_host_model

// file: verif/serial_clock_synth_control_port_test.sv
/*
  serial_clock_synth_control_port_test: self-checking bench for the
  control port, driving it through the host model.
  assumes: control port and host model compiled beforehand.
*/
`timescale 1ns/100ps
module serial_clock_synth_control_port_test;
  import scsc_pkg::*;

  localparam int FREEZE = 8;
  localparam int CEILING = 30000;

  logic sys_clk_in;
  logic rst_in;
  logic gate_pin;
  logic strobe, req, rnw, host_d, d_out, d_oe, d_line;
  logic differential_out_large, ext_ref, load_stop, load_gate, pclk_hold, differential_out_low;
  logic cp_high, cp_inv, cp_hiz, osc_off, ext_osc, osc_rst, relock, freeze;
  logic [FILTER_W-1:0] filt;
  logic [MUX_W-1:0]    mux;
  logic [P_W-1:0]      p_m1;
  logic [L_W-1:0]      l_m1;
  logic [R_W-1:0]      r_mod;
  logic [N_W-1:0]      n_mod;
  logic [WORD_W-1:0]   fields;
  logic [WORD_W-1:0]   rd;
  logic [WORD_W-1:0]   w1;
  logic [WORD_W-1:0]   w2;
  int n_mismatch;
  int comparisons;
  int relocks;
  int frozen;
  int cycles;

  // device drives the line while enabled, else the host does
  assign d_line = d_oe ? d_out : host_d;
  assign fields = {n_mod, r_mod, l_m1, p_m1, mux, osc_rst, ext_osc, osc_off,
    cp_hiz, cp_inv, cp_high, differential_out_low, pclk_hold, load_stop, filt, ext_ref,
    differential_out_large};
  // no-change word: mux 0 and p 3 kept, oscillator reset cleared
  assign w1 = {14'h2abc, 10'h2f5, 4'ha, 4'h3, 2'h0, 1'b0, 12'ha5c};
  // boundary moduli, p and mux changed
  assign w2 = {14'h0002, 10'h001, 4'hf, 4'h0, 2'h1, 1'b0, 12'hfff};

  scsc_control_port #(.FREEZE_CYCLES(FREEZE)) i_dut (
    .sys_clk_in              (sys_clk_in),
    .rst_in                  (rst_in),
    .chip_select_strobe_in   (strobe),
    .xfer_request_in         (req),
    .read_not_write_in       (rnw),
    .serial_data_in          (d_line),
    .serial_data_out         (d_out),
    .serial_data_oe_out      (d_oe),
    .load_clock_gate_pin_in  (gate_pin),
    .differential_out_large_swing_out    (differential_out_large),
    .ext_ref_select_out      (ext_ref),
    .loop_filter_sel_out     (filt),
    .load_clock_stop_out     (load_stop),
    .load_clock_gate_out     (load_gate),
    .pixel_clock_hold_out    (pclk_hold),
    .differential_out_out_low_out        (differential_out_low),
    .cp_high_current_out     (cp_high),
    .cp_invert_out           (cp_inv),
    .cp_hiz_out              (cp_hiz),
    .osc_disable_out         (osc_off),
    .external_osc_path_on_out(ext_osc),
    .osc_reset_bit_out       (osc_rst),
    .clock_mux_sel_out       (mux),
    .p_modulus_m1_out        (p_m1),
    .l_modulus_m1_out        (l_m1),
    .r_modulus_out           (r_mod),
    .n_modulus_out           (n_mod),
    .pll_relock_out          (relock),
    .pclk_freeze_out         (freeze)
  );

  scsc_host_model i_host (
    .sys_clk_in    (sys_clk_in),
    .data_line_in  (d_line),
    .strobe_out    (strobe),
    .xfer_req_out  (req),
    .rnw_out       (rnw),
    .data_drive_out(host_d)
  );

  // 200 mhz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // relock pulses, frozen cycles and the hang limit
  always @(posedge sys_clk_in) begin
    cycles = cycles + 1;
    if (relock === 1'b1) relocks = relocks + 1;
    if (freeze === 1'b1) frozen = frozen + 1;
    if (cycles == CEILING) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end

  // compare with case inequality, report at once
  task automatic chk(input logic [WORD_W-1:0] got,
                     input logic [WORD_W-1:0] exp,
                     input string             what);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    rst_in = 1'b1;
    gate_pin = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    relocks = 0;
    frozen = 0;
    cycles = 0;
    repeat (8) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk(fields, WORD_RESET, "power-up word");
    chk(fields >> 4, WORD_RESET >> 4, "power-up gates");
    chk(fields >> 7, WORD_RESET >> 7, "power-up pump");
    chk(fields >> 9, WORD_RESET >> 9, "power-up osc");
    chk(fields >> 12, WORD_RESET >> 12, "power-up src");
    chk(fields >> 15, WORD_RESET >> 15, "power-up p l");
    chk(fields >> 23, WORD_RESET >> 23, "power-up r n");
    chk({46'h0, d_oe}, '0, "idle drive");
    // refreshed read, then plain read of the rotated shift register
    i_host.read_word(1'b1, rd);
    chk(rd, WORD_RESET, "read refresh");
    i_host.read_word(1'b0, rd);
    chk(rd, WORD_RESET, "read plain");
    chk(fields, WORD_RESET, "read keeps");
    chk(WORD_W'(relocks), '0, "read relock");
    // write that leaves mux and p as they were
    i_host.write_word(w1, 1'b1);
    repeat (8) @(negedge sys_clk_in);
    chk(fields, w1, "write one");
    chk(WORD_W'(relocks), 47'h1, "relock one");
    chk(WORD_W'(frozen), '0, "no freeze");
    // write without the final request
    i_host.write_word(~w1, 1'b0);
    repeat (8) @(negedge sys_clk_in);
    chk(fields, w1, "no load");
    chk(WORD_W'(relocks), 47'h1, "no relock");
    // write that changes mux and p
    i_host.write_word(w2, 1'b1);
    repeat (FREEZE + 8) @(negedge sys_clk_in);
    chk(fields, w2, "write two");
    chk(WORD_W'(relocks), 47'h2, "relock two");
    chk(WORD_W'(frozen), WORD_W'(FREEZE), "freeze span");
    i_host.read_word(1'b1, rd);
    chk(rd, w2, "read back");
    chk(fields, w2, "read keeps two");
    chk(WORD_W'(relocks), 47'h2, "read relock two");
    // gate pin reaches the output without touching the word
    gate_pin = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    chk({46'h0, load_gate}, 47'h1, "gate on");
    gate_pin = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk({46'h0, load_gate}, '0, "gate off");
    chk(fields, w2, "gate keeps");
    conclude();
  end
endmodule : serial_clock_synth_control_port_test
